// File: verification/pmc_osc_model.sv
// oscillator side model: flags the selected source stable after settling
// assumes enables from pmc_top; SLOW_START picks the long settle time
`timescale 1ns/1ps

module pmc_osc_model #(
  parameter int FAST = 20,
  parameter int SLOW = 600
) (
  input  wire logic       CLK,
  input  wire logic       RST_N,
  input  wire logic [2:0] SYS_SRC,
  input  wire logic       POSC_EN,
  input  wire logic       FRC_EN,
  input  wire logic       SOSC_EN,
  input  wire logic       LOW_POWER_INTERNAL_OSC_EN,
  input  wire logic       SLOW_START,
  output logic            OSC_READY
);
  logic       sel_on;
  logic [2:0] last_src;
  int         run_cnt;
  always_comb begin
    case (SYS_SRC)
      3'h0: sel_on = POSC_EN;
      3'h1, 3'h2: sel_on = FRC_EN;
      3'h3: sel_on = LOW_POWER_INTERNAL_OSC_EN;
      default: sel_on = SOSC_EN;
    endcase
  end
  // a stopped or newly chosen source must settle again
  always_ff @(posedge CLK) begin
    last_src <= SYS_SRC;
    if (!RST_N || !sel_on || SYS_SRC != last_src) run_cnt <= 0;
    else if (run_cnt < SLOW) run_cnt <= run_cnt + 1;
  end
  assign OSC_READY = sel_on && run_cnt >= (SLOW_START ? SLOW : FAST);
endmodule // pmc_osc_model

// File: verification/pmc_top_props.sv
// checker for the power-mode controller, port relations only
// assumes it is bound into pmc_top and sees that module's ports
`timescale 1ns/1ps

module pmc_top_props
  import pmc_pkg::*;
(
  input wire logic          CLK,
  input wire logic          RST_N,
  input wire logic [4:0]    ADDR,
  input wire logic          WR,
  input wire logic          CPU_CLK_EN,
  input wire logic          CPU_RESUME,
  input wire logic [2:0]    SYS_SRC,
  input wire logic [7:0]    PERIPH_CLK_EN,
  input wire logic          PB_TICK,
  input wire logic          FAIL_SAFE_CLOCK_MONITOR_EN,
  input wire logic          BOR_EN,
  input wire logic          PIN_HOLD
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // ----------------------------------------------------------------
  // halted-cycle counter, saturating so a long sleep cannot wrap
  // ----------------------------------------------------------------
  logic [12:0] hold_cnt_reg;
  always_ff @(posedge CLK) begin
    if (!RST_N || !PIN_HOLD) hold_cnt_reg <= 13'h0;
    else if (hold_cnt_reg != 13'h1fff) hold_cnt_reg <= hold_cnt_reg + 13'h1;
  end
  function automatic logic [12:0] min_wait(logic [2:0] s);
    case (s)
      3'h1, 3'h2: return {1'b0, PMC_FRC_CYC};
      3'h3: return {1'b0, PMC_LOW_POWER_INTERNAL_OSC_CYC};
      3'h4: return {1'b0, PMC_SOSC_CYC};
      default: return {1'b0, PMC_POSC_CYC};
    endcase
  endfunction

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  chk_sleep_halts: assert property (PIN_HOLD |-> !CPU_CLK_EN
    && !PERIPH_CLK_EN[7]) else $error("cpu or system_clock lane on in sleep");
  chk_fail_safe_clock_monitor_off: assert property (PIN_HOLD |-> !FAIL_SAFE_CLOCK_MONITOR_EN)
    else $error("clock monitor running while halted");
  chk_bor_kept: assert property (BOR_EN)
    else $error("brown-out reset disabled");
  chk_sw_entry: assert property ($fell(CPU_CLK_EN) |-> $past(WR)
    && $past(ADDR) == PMC_ADR_CMD) else $error("halt without command");
  chk_resume_pulse: assert property (CPU_RESUME |-> CPU_CLK_EN
    ##1 !CPU_RESUME) else $error("resume not a single clocked pulse");
  chk_bus_stops: assert property (PIN_HOLD |-> !PB_TICK)
    else $error("peripheral bus ticking in sleep");
  chk_wake_delay: assert property ($fell(PIN_HOLD)
    |-> hold_cnt_reg >= min_wait(SYS_SRC))
    else $error("left sleep before the oscillator delay");
  chk_idle_ticks: assert property (!CPU_CLK_EN && !PIN_HOLD
    |-> ##[0:8] (PB_TICK || CPU_CLK_EN || PIN_HOLD))
    else $error("peripheral bus stopped in idle");
  chk_src_kept: assert property (PIN_HOLD |-> $stable(SYS_SRC))
    else $error("clock source changed while halted");
endmodule // pmc_top_props

bind pmc_top pmc_top_props u_props (
  .CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WR(WR),
  .CPU_CLK_EN(CPU_CLK_EN), .CPU_RESUME(CPU_RESUME), .SYS_SRC(SYS_SRC),
  .PERIPH_CLK_EN(PERIPH_CLK_EN), .PB_TICK(PB_TICK), .FAIL_SAFE_CLOCK_MONITOR_EN(FAIL_SAFE_CLOCK_MONITOR_EN),
  .BOR_EN(BOR_EN), .PIN_HOLD(PIN_HOLD)
);

// File: verification/testbench.sv
// self-checking bench for the power-mode controller
// assumes pmc_top, its bound checker and the oscillator model
`timescale 1ns/1ps

module testbench
  import pmc_pkg::*;
;
  logic        clk, rst_n, wr, rd, usb, slow, osc_rdy, cpu_en, resume;
  logic        pb_tick, posc_en, frc_en, sosc_en, low_power_internal_osc_en, fail_safe_clock_monitor_en;
  logic        bor_en, hold;
  logic [4:0]  addr;
  logic [31:0] wdata, rdata, d;
  logic [6:0]  wake;
  logic [2:0]  src, fdiv;
  logic [7:0]  pclk_en;
  int          mismatches, n_compared, n;

  pmc_top dut (
    .CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .WAKE_REQ(wake), .OSC_READY(osc_rdy),
    .USB_KEEP_OSC(usb), .CPU_CLK_EN(cpu_en), .CPU_RESUME(resume),
    .SYS_SRC(src), .FRC_DIV(fdiv), .PERIPH_CLK_EN(pclk_en),
    .PB_TICK(pb_tick), .POSC_EN(posc_en), .FRC_EN(frc_en),
    .SOSC_EN(sosc_en), .LOW_POWER_INTERNAL_OSC_EN(low_power_internal_osc_en), .FAIL_SAFE_CLOCK_MONITOR_EN(fail_safe_clock_monitor_en),
    .BOR_EN(bor_en), .PIN_HOLD(hold)
  );
  pmc_osc_model osc (
    .CLK(clk), .RST_N(rst_n), .SYS_SRC(src), .POSC_EN(posc_en),
    .FRC_EN(frc_en), .SOSC_EN(sosc_en), .LOW_POWER_INTERNAL_OSC_EN(low_power_internal_osc_en),
    .SLOW_START(slow), .OSC_READY(osc_rdy)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(string name, logic [31:0] got, logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic stop_test();
    if (mismatches == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wr_reg(logic [4:0] a, logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(logic [4:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic cycles(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // resume is a one-cycle pulse, so it is looked at every cycle
  task automatic wait_resume();
    n = 0;
    while (resume !== 1'b1 && n < 6000) begin
      cycles(1);
      n++;
    end
  endtask
  function automatic logic [31:0] cfg(logic [2:0] s, f, logic [1:0] p);
    return (32'(s) << PMC_SRC_LSB) | (32'(f) << PMC_FDIV_LSB) |
           (32'(p) << PMC_PDIV_LSB);
  endfunction
  function automatic logic sel_en(logic [2:0] s);
    case (s)
      3'h0: return posc_en;
      3'h1, 3'h2: return frc_en;
      3'h3: return low_power_internal_osc_en;
      default: return sosc_en;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk("rst", 32'({cpu_en, src, fdiv, pclk_en, fail_safe_clock_monitor_en, hold, bor_en}),
        32'({1'b1, PMC_SRC_FRC, 3'h0, 8'hff, 3'b101}));
    rd_reg(PMC_ADR_WEN);
    chk("wen", d, 32'h0000_007f);
    wr_reg(5'h18, 32'h0000_0002);
    chk("unmapped", 32'(cpu_en), 32'h1);
  endtask
  task automatic t_src();
    for (int s = 0; s < 5; s++) begin
      wr_reg(PMC_ADR_CLK, cfg(3'(s), 3'(s), 2'h0));
      chk("src", 32'({src, fdiv, sel_en(src)}),
          32'({3'(s), 3'(s), 1'b1}));
    end
  endtask
  task automatic t_pb();
    for (int p = 0; p < 4; p++) begin
      wr_reg(PMC_ADR_CLK, cfg(PMC_SRC_FRC, 3'h0, 2'(p)));
      cycles(8);
      n = 0;
      repeat (32) begin
        cycles(1);
        n += int'(pb_tick);
      end
      chk("pb_ticks", 32'(n), 32'(32 >> p));
      chk("cpu_full", 32'(cpu_en), 32'h1);
    end
  endtask
  task automatic t_dis();
    wr_reg(PMC_ADR_DIS, 32'h0000_0081);
    chk("dis", 32'({pclk_en, cpu_en}), 32'({8'h7e, 1'b1}));
    rd_reg(PMC_ADR_DIS);
    chk("dis_rd", d, 32'h0000_0081);
    wr_reg(PMC_ADR_DIS, 32'h0000_0000);
  endtask
  task automatic t_idle();
    logic [2:0] srcs [4] = '{PMC_SRC_POSC, PMC_SRC_FRCD, PMC_SRC_SOSC,
                             PMC_SRC_LOW_POWER_INTERNAL_OSC};
    foreach (srcs[i]) begin
      wr_reg(PMC_ADR_CLK, cfg(srcs[i], 3'h5, 2'h1));
      wr_reg(PMC_ADR_CMD, 32'h0000_0001);
      chk("idle", 32'({cpu_en, hold, fail_safe_clock_monitor_en, pclk_en, fdiv, sel_en(src)}),
          32'({3'b001, 8'hff, 3'h5, 1'b1}));
      cycles(20);
      chk("idle_stay", 32'(cpu_en), 32'h0);
      wake <= 7'h08;
      wait_resume();
      chk("idle_wake", 32'({cpu_en, n < 20}), 32'h3);
      wake <= 7'h00;
      cycles(5);
    end
  endtask
  task automatic t_sleep(logic sl, logic keep);
    // the usb hold passes a synchroniser, so it is set well ahead
    slow <= sl;
    usb <= keep;
    wr_reg(PMC_ADR_STAT, 32'h0000_7f00);
    wr_reg(PMC_ADR_CLK, cfg(PMC_SRC_FRC, 3'h0, 2'h0));
    wr_reg(PMC_ADR_WEN, 32'h0000_007d);
    wr_reg(PMC_ADR_CMD, 32'h0000_0003);
    chk("sleep",
        32'({cpu_en, hold, fail_safe_clock_monitor_en, bor_en, low_power_internal_osc_en, pclk_en, frc_en,
        pb_tick}), 32'({5'b01011, PMC_SLEEP_OK, keep, 1'b0}));
    rd_reg(PMC_ADR_STAT);
    chk("stat_sleep", 32'(d[1:0]), 32'h2);
    wake <= 7'h02;
    cycles(30);
    chk("masked", 32'(hold), 32'h1);
    wake <= 7'h03;
    wait_resume();
    chk("delay", 32'(n > (sl ? 600 : 200) && n < (sl ? 620 : 220)),
        32'h1);
    chk("run", 32'({cpu_en, hold, fail_safe_clock_monitor_en, frc_en}), 32'hb);
    rd_reg(PMC_ADR_STAT);
    chk("stat_run", 32'({d[8], d[2], d[1:0]}), 32'hc);
    wake <= 7'h00;
    usb <= 1'b0;
    slow <= 1'b0;
    wr_reg(PMC_ADR_WEN, 32'h0000_007f);
  endtask

  initial begin
    rst_n = 1'b0;
    {wr, rd, usb, slow} = 4'h0;
    addr = 5'h00;
    wdata = 32'h0000_0000;
    wake = 7'h00;
    mismatches = 0;
    n_compared = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    t_reset();
    t_src();
    t_pb();
    t_dis();
    t_idle();
    t_sleep(1'b0, 1'b0);
    t_sleep(1'b1, 1'b0);
    t_sleep(1'b0, 1'b1);
    stop_test();
  end
  // the run needs some 1500 cycles; this leaves a wide margin
  initial begin
    #(50 * 20000);
    mismatches++;
    stop_test();
  end
endmodule // testbench

// File: verilog/pmc_div.sv
// peripheral bus scaler: one-cycle tick every 2^code system cycles
// assumes code changes are rare; counter restarts on a change
`timescale 1ns/1ps

module pmc_div (
  input  wire logic       CLK,
  input  wire logic       RST_N,
  input  wire logic [1:0] code,
  output logic            tick
);

  typedef struct packed {
    logic [2:0] cnt;
    logic [1:0] code;
    logic       tick;
  } pmc_div_t;

  pmc_div_t st_reg;
  pmc_div_t st_next;
  logic [2:0] last;

  always_comb begin
    st_next      = st_reg;
    last         = 3'((4'h1 << code) - 4'h1);
    st_next.code = code;
    st_next.tick = 1'b0;
    if (code != st_reg.code || st_reg.cnt >= last) begin
      st_next.cnt  = 3'h0;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt  = st_reg.cnt + 3'h1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;

endmodule // pmc_div

// File: verilog/pmc_pkg.sv
// power-mode clock gating package: register map, fields, states, timing
// assumes a 20 MHz controller clock; nothing else is shared
package pmc_pkg;

  // ------------------------------------------------------------------
  // register offsets (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [4:0] PMC_ADR_CLK  = 5'h00;
  localparam logic [4:0] PMC_ADR_CMD  = 5'h04;
  localparam logic [4:0] PMC_ADR_DIS  = 5'h08;
  localparam logic [4:0] PMC_ADR_WEN  = 5'h0C;
  localparam logic [4:0] PMC_ADR_STAT = 5'h10;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int PMC_SRC_LSB   = 0;   // clock config [2:0]
  localparam int PMC_FDIV_LSB  = 4;   // clock config [6:4]
  localparam int PMC_PDIV_LSB  = 8;   // clock config [9:8]
  localparam int PMC_CMD_IDLE  = 0;
  localparam int PMC_CMD_SLEEP = 1;
  localparam int PMC_ST_OSC    = 2;   // status [1:0] state, [2] osc ok
  localparam int PMC_ST_WAKE   = 8;   // status [14:8] wake sources

  localparam int PMC_NPER  = 8;       // peripheral clock lanes
  localparam int PMC_NWAKE = 7;       // wake sources

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [2:0] PMC_RST_FDIV = 3'h0;
  localparam logic [1:0] PMC_RST_PDIV = 2'h0;
  localparam logic [7:0] PMC_RST_DIS  = 8'h00;
  localparam logic [6:0] PMC_RST_WEN  = 7'h7F;
  // lanes 0..6 run from their own clocks and may stay alive in sleep
  localparam logic [7:0] PMC_SLEEP_OK = 8'h7F;

  typedef enum logic [2:0] {
    PMC_SRC_POSC  = 3'b000,
    PMC_SRC_FRC   = 3'b001,
    PMC_SRC_FRCD  = 3'b010,
    PMC_SRC_LOW_POWER_INTERNAL_OSC  = 3'b011,
    PMC_SRC_SOSC  = 3'b100
  } pmc_src_t;

  typedef enum logic [1:0] {
    PMC_RUN   = 2'b00,
    PMC_IDLE  = 2'b01,
    PMC_SLEEP = 2'b10,
    PMC_WAKE  = 2'b11
  } pmc_state_t;

  // ------------------------------------------------------------------
  // wake-up delays per oscillator
  // ------------------------------------------------------------------
  localparam int PMC_CLK_MHZ   = 20;
  localparam int PMC_POSC_US   = 100;
  localparam int PMC_FRC_US    = 10;
  localparam int PMC_LOW_POWER_INTERNAL_OSC_US   = 100;
  localparam int PMC_SOSC_US   = 200;
  localparam logic [11:0] PMC_POSC_CYC = 12'(PMC_POSC_US * PMC_CLK_MHZ);
  localparam logic [11:0] PMC_FRC_CYC  = 12'(PMC_FRC_US * PMC_CLK_MHZ);
  localparam logic [11:0] PMC_LOW_POWER_INTERNAL_OSC_CYC = 12'(PMC_LOW_POWER_INTERNAL_OSC_US * PMC_CLK_MHZ);
  localparam logic [11:0] PMC_SOSC_CYC = 12'(PMC_SOSC_US * PMC_CLK_MHZ);

endpackage

// File: verilog/pmc_sync.sv
// three-stage synchroniser bank for asynchronous level inputs
// assumes inputs are slow levels; output follows once stages 2 and 3 agree
`timescale 1ns/1ps

module pmc_sync #(
  parameter int W = 8
) (
  input  wire logic         CLK,
  input  wire logic         RST_N,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } pmc_sync_t;

  pmc_sync_t st_reg;
  pmc_sync_t st_next;

  // ------------------------------------------------------------------
  // per-bit filter
  // ------------------------------------------------------------------
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = async_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < W; i++) begin
      // stage 1 is read only by stage 2; settle on 2/3 agreement
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.q[i] = st_reg.s2[i];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_out = st_reg.q;

endmodule // pmc_sync

// File: verilog/pmc_top.sv
// power-mode controller: clock source select, gating, idle/sleep, wake
// assumes oscillator ready and wake requests arrive asynchronously
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ps

// Operation
// - modes entered only by software writes
// - cpu clock from posc, frc, low_power_internal_osc or sosc
// - peripheral clock at programmable fraction
// - idle and sleep stop cpu clock
// - posc idle keeps oscillator, peripherals run
// - frc idle keeps postscaler, peripherals run
// - sosc and low_power_internal_osc idle supported too
// - sleep stops cpu, source (except low_power_internal_osc), system_clock peripherals
// - listed sleep-capable peripherals keep running
// - active peripherals can wake from sleep
// - oscillator dependent delay after sleep
// - fail-safe monitor off during sleep
// - brown-out reset stays on in sleep
// - sleep entry never clears watchdog
// - pins hold drive state in sleep
// - usb can keep posc or frc alive
// - per-module software clock disable
module pmc_top
  import pmc_pkg::*;
(
  input  wire logic                 CLK,
  input  wire logic                 RST_N,
  input  wire logic [4:0]           ADDR,
  input  wire logic [31:0]          WDATA,
  input  wire logic                 WR,
  input  wire logic                 RD,
  output logic      [31:0]          RDATA,
  input  wire logic [PMC_NWAKE-1:0] WAKE_REQ,
  input  wire logic                 OSC_READY,
  input  wire logic                 USB_KEEP_OSC,
  output logic                      CPU_CLK_EN,
  output logic                      CPU_RESUME,
  output logic [2:0]                SYS_SRC,
  output logic [2:0]                FRC_DIV,
  output logic [PMC_NPER-1:0]       PERIPH_CLK_EN,
  output logic                      PB_TICK,
  output logic                      POSC_EN,
  output logic                      FRC_EN,
  output logic                      SOSC_EN,
  output logic                      LOW_POWER_INTERNAL_OSC_EN,
  output logic                      FAIL_SAFE_CLOCK_MONITOR_EN,
  output logic                      BOR_EN,
  output logic                      PIN_HOLD
);

  typedef struct packed {
    pmc_state_t          state;
    pmc_src_t            src;
    logic [2:0]          fdiv;
    logic [1:0]          pdiv;
    logic [PMC_NPER-1:0] dis;
    logic [6:0]          wen;
    logic [6:0]          wflag;
    logic [11:0]         dly;
    logic [31:0]         rdata;
    logic                resume;
    logic                cpu_en;
    logic [PMC_NPER-1:0] per_en;
    logic                pb_tick;
    logic                posc_en;
    logic                frc_en;
    logic                sosc_en;
    logic                fail_safe_clock_monitor_en;
    logic                pin_hold;
    logic                low_power_internal_osc_en;
    logic                bor_en;
  } pmc_top_t;

  pmc_top_t st_reg;
  pmc_top_t st_next;

  logic [PMC_NWAKE+1:0] sync_q;
  logic [6:0]           wake_hit;
  logic                 osc_ok;
  logic                 div_tick;
  logic                 asleep;
  logic                 keep;
  logic [11:0]          wake_dly;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  pmc_sync #(
    .W        (PMC_NWAKE + 2)
  ) u_sync (
    .CLK      (CLK),
    .RST_N    (RST_N),
    .async_in ({USB_KEEP_OSC, OSC_READY, WAKE_REQ}),
    .sync_out (sync_q)
  );

  pmc_div u_div (
    .CLK      (CLK),
    .RST_N    (RST_N),
    .code     (st_reg.pdiv),
    .tick     (div_tick)
  );

  assign osc_ok   = sync_q[PMC_NWAKE];
  assign wake_hit = sync_q[PMC_NWAKE-1:0] & st_reg.wen;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    st_next        = st_reg;
    st_next.resume = 1'b0;
    st_next.rdata  = 32'h0000_0000;

    // ----------------------------------------------------------------
    // sticky wake flags
    // ----------------------------------------------------------------
    // wake flags are sticky; a new event beats a clear in the same cycle
    if (WR && ADDR == PMC_ADR_STAT) begin
      st_next.wflag = st_reg.wflag & ~WDATA[PMC_ST_WAKE +: 7];
    end
    st_next.wflag = st_next.wflag | wake_hit;

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    if (WR) begin
      case (ADDR)
        PMC_ADR_CLK: begin
          st_next.src  = pmc_src_t'(WDATA[PMC_SRC_LSB +: 3]);
          st_next.fdiv = WDATA[PMC_FDIV_LSB +: 3];
          st_next.pdiv = WDATA[PMC_PDIV_LSB +: 2];
        end
        PMC_ADR_DIS: st_next.dis = WDATA[PMC_NPER-1:0];
        PMC_ADR_WEN: st_next.wen = WDATA[6:0];
        default: ;
      endcase
    end

    // ----------------------------------------------------------------
    // register reads, answered one cycle later
    // ----------------------------------------------------------------
    if (RD) begin
      case (ADDR)
        PMC_ADR_CLK: begin
          st_next.rdata[PMC_SRC_LSB +: 3]  = st_reg.src;
          st_next.rdata[PMC_FDIV_LSB +: 3] = st_reg.fdiv;
          st_next.rdata[PMC_PDIV_LSB +: 2] = st_reg.pdiv;
        end
        PMC_ADR_DIS:  st_next.rdata[PMC_NPER-1:0] = st_reg.dis;
        PMC_ADR_WEN:  st_next.rdata[6:0] = st_reg.wen;
        PMC_ADR_STAT: begin
          st_next.rdata[1:0]               = st_reg.state;
          st_next.rdata[PMC_ST_OSC]        = osc_ok;
          st_next.rdata[PMC_ST_WAKE +: 7]  = st_reg.wflag;
        end
        default: ;   // command and unmapped offsets read as zero
      endcase
    end

    // ----------------------------------------------------------------
    // mode sequencing
    // ----------------------------------------------------------------
    // delay depends on the oscillator that must restart
    case (st_reg.src)
      PMC_SRC_POSC: wake_dly = PMC_POSC_CYC;
      PMC_SRC_LOW_POWER_INTERNAL_OSC: wake_dly = PMC_LOW_POWER_INTERNAL_OSC_CYC;
      PMC_SRC_SOSC: wake_dly = PMC_SOSC_CYC;
      default:      wake_dly = PMC_FRC_CYC;
    endcase

    case (st_reg.state)
      PMC_RUN: begin
        // only a software command leaves run
        // a wake seen while running only marks its flag
        if (WR && ADDR == PMC_ADR_CMD) begin
          if (WDATA[PMC_CMD_SLEEP]) begin
            st_next.state = PMC_SLEEP;
          end else if (WDATA[PMC_CMD_IDLE]) begin
            st_next.state = PMC_IDLE;  // any source
          end
        end
      end
      PMC_IDLE: begin
        // source kept running, so no start-up wait is needed
        if (|wake_hit) begin
          st_next.state  = PMC_RUN;
          st_next.resume = 1'b1;
        end
      end
      PMC_SLEEP: begin
        // the source restarts in wake, so the delay counts from there
        if (|wake_hit) begin
          st_next.state = PMC_WAKE;
          st_next.dly   = wake_dly;
        end
      end
      PMC_WAKE: begin
        // both the delay and a stable source are needed before run
        if (st_reg.dly != 12'h000) begin
          st_next.dly = st_reg.dly - 12'h001;
        end else if (osc_ok) begin
          st_next.state  = PMC_RUN;
          st_next.resume = 1'b1;
        end
      end
      default: st_next.state = PMC_RUN;
    endcase

    // ----------------------------------------------------------------
    // gating outputs, registered from the next state
    // ----------------------------------------------------------------
    asleep = (st_next.state == PMC_SLEEP) || (st_next.state == PMC_WAKE);
    keep   = sync_q[PMC_NWAKE+1];

    // ----------------------------------------------------------------
    // cpu and peripheral gates
    // ----------------------------------------------------------------
    // cpu halted in idle and sleep
    st_next.cpu_en = (st_next.state == PMC_RUN);

    // peripherals keep clocks in idle unless disabled
    // in sleep only lanes with their own clock survive
    for (int i = 0; i < PMC_NPER; i++) begin
      st_next.per_en[i] = !st_next.dis[i] &&
                          (!asleep || PMC_SLEEP_OK[i]);
    end
    st_next.pb_tick = div_tick && !asleep;

    // ----------------------------------------------------------------
    // oscillator enables
    // ----------------------------------------------------------------
    // posc and frc stop in sleep unless usb holds them; sosc always stops
    st_next.posc_en = (st_next.src == PMC_SRC_POSC) &&
                      (!asleep || keep);
    st_next.frc_en  = ((st_next.src == PMC_SRC_FRC) ||
                       (st_next.src == PMC_SRC_FRCD)) &&
                      (!asleep || keep);
    st_next.sosc_en = (st_next.src == PMC_SRC_SOSC) && !asleep;
    // restart needs the source back on during the wake delay
    if (st_next.state == PMC_WAKE) begin
      st_next.posc_en = (st_next.src == PMC_SRC_POSC);
      st_next.frc_en  = (st_next.src == PMC_SRC_FRC) ||
                        (st_next.src == PMC_SRC_FRCD);
      st_next.sosc_en = (st_next.src == PMC_SRC_SOSC);
    end

    // ----------------------------------------------------------------
    // monitors, pins and always-on functions
    // ----------------------------------------------------------------
    st_next.fail_safe_clock_monitor_en  = !asleep;
    st_next.pin_hold = asleep;
    // kept as flops so every output leaves a register
    st_next.low_power_internal_osc_en  = 1'b1;
    st_next.bor_en   = 1'b1;
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st_reg         <= '0;
      st_reg.state   <= PMC_RUN;
      st_reg.src     <= PMC_SRC_FRC;
      st_reg.fdiv    <= PMC_RST_FDIV;
      st_reg.pdiv    <= PMC_RST_PDIV;
      st_reg.dis     <= PMC_RST_DIS;
      st_reg.wen     <= PMC_RST_WEN;
      st_reg.cpu_en  <= 1'b1;
      st_reg.per_en  <= ~PMC_RST_DIS;
      st_reg.frc_en  <= 1'b1;
      st_reg.fail_safe_clock_monitor_en <= 1'b1;
      st_reg.low_power_internal_osc_en <= 1'b1;
      st_reg.bor_en  <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign RDATA         = st_reg.rdata;
  assign CPU_CLK_EN    = st_reg.cpu_en;
  assign CPU_RESUME    = st_reg.resume;
  assign SYS_SRC       = st_reg.src;
  assign FRC_DIV       = st_reg.fdiv;
  assign PERIPH_CLK_EN = st_reg.per_en;
  assign PB_TICK       = st_reg.pb_tick;
  assign POSC_EN       = st_reg.posc_en;
  assign FRC_EN        = st_reg.frc_en;
  assign SOSC_EN       = st_reg.sosc_en;
  // watchdog counter lives on this oscillator; sleep never clears it
  assign LOW_POWER_INTERNAL_OSC_EN       = st_reg.low_power_internal_osc_en;
  assign FAIL_SAFE_CLOCK_MONITOR_EN       = st_reg.fail_safe_clock_monitor_en;
  // brown-out stays armed in every mode
  assign BOR_EN        = st_reg.bor_en;
  assign PIN_HOLD      = st_reg.pin_hold;

endmodule // pmc_top
